// >>> css_top.sv
`timescale 1ns/100ps
module css_top
  import css_pkg::*;
#(
  parameter int MS_SHORT_CYC   = CYC_4P1MS,
  parameter int MS_LONG_CYC    = CYC_65MS,
  parameter int K128_SHORT_CYC = CYC_4MS,
  parameter int K128_LONG_CYC  = CYC_64MS,
  parameter int LF_WAKE_LONG   = WAKE_CK_LF32K
) (
  // clock and reset
  input  wire logic              CLK_IN,
  input  wire logic              ARST_N_IN,
  // oscillator pins
  input  wire logic              CRYSTAL_INPUT_PIN_IN,
  input  wire logic              RC_OSC_IN,
  input  wire logic              K128_OSC_IN,
  input  wire logic              TIMER_OSCILLATOR_PIN_IN,
  input  wire logic              WDT_OSC_IN,
  // fuses and calibration
  input  wire logic              FUSES_WRITTEN_IN,
  input  wire logic [3:0]        CLOCK_SOURCE_SELECT_FUSES_IN,
  input  wire logic [1:0]        STARTUP_TIME_FUSES_IN,
  input  wire logic              DIVIDE_BY_EIGHT_FUSE_IN,
  input  wire logic              RESET_PIN_DISABLE_FUSE_IN,
  input  wire logic [7:0]        FACTORY_CAL_IN,
  // sleep control
  input  wire logic              SLEEP_IN,
  input  wire logic              WAKE_IN,
  // register port
  input  wire logic [ADDR_W-1:0] ADDR_IN,
  input  wire logic [7:0]        WR_DATA_IN,
  input  wire logic              WR_STB_IN,
  input  wire logic              RD_STB_IN,
  output logic      [7:0]        RD_DATA_OUT,
  // clock and reset outputs
  output logic                   SYS_CLK_EN_OUT,
  output logic                   WDT_CLK_EN_OUT,
  output logic                   CORE_RST_N_OUT,
  output logic                   CORE_RUN_OUT,
  output logic      [1:0]        CLK_SRC_OUT,
  output logic                   CFG_RESERVED_OUT,
  output logic      [7:0]        OSCILLATOR_TRIM_OUT,
  output logic      [3:0]        PRESCALER_SELECT_OUT
);

  typedef struct packed {
    css_state_t  state;
    logic [15:0] cnt;
    logic [22:0] ms;
    logic [3:0]  sel;
    logic [1:0]  stu;
    logic        rstdis;
    css_src_t    src;
    logic        rsvd;
    logic [7:0]  trim;
    logic [3:0]  presc;
    logic [7:0]  rdata;
    logic        sys_en;
    logic        wdt_en;
    logic        core_rst_n;
    logic        run;
  } css_top_st_t;

  // fuse registers start at shipped values
  localparam css_top_st_t ST_RESET = '{
    state:      ST_LOAD,
    cnt:        16'h0000,
    ms:         23'h00_0000,
    sel:        SHIP_SEL,
    stu:        SHIP_STU,
    rstdis:     SHIP_RSTDIS,
    src:        SRC_RC,
    rsvd:       1'b0,
    trim:       TRIM_RST,
    presc:      PRESC_DIV8,
    rdata:      8'h00,
    sys_en:     1'b0,
    wdt_en:     1'b0,
    core_rst_n: 1'b0,
    run:        1'b0
  };

  css_top_st_t st_q;
  css_top_st_t st_d;

  logic [4:0] rise;
  logic       src_rise;
  logic [3:0] sel_in;
  logic [1:0] stu_in;
  logic       div8_in;
  logic       rstdis_in;
  css_ms_t    ms_mode;
  logic [7:0] status;

  // pins are asynchronous to CLK_IN; sampled edges must stay well
  // below half the 100 MHz rate or cycles are missed
  css_sync #(
    .N (5)
  ) u_sync (
    .clk_in    (CLK_IN),
    .arst_n_in (ARST_N_IN),
    .raw_in    ({WDT_OSC_IN,
                 TIMER_OSCILLATOR_PIN_IN,
                 K128_OSC_IN,
                 RC_OSC_IN,
                 CRYSTAL_INPUT_PIN_IN}),
    .rise_out  (rise)
  );

  // erased fuse array falls back to delivery settings
  assign sel_in    = FUSES_WRITTEN_IN ? CLOCK_SOURCE_SELECT_FUSES_IN
                                      : SHIP_SEL;
  assign stu_in    = FUSES_WRITTEN_IN ? STARTUP_TIME_FUSES_IN : SHIP_STU;
  assign div8_in   = FUSES_WRITTEN_IN ? DIVIDE_BY_EIGHT_FUSE_IN : SHIP_DIV8;
  assign rstdis_in = FUSES_WRITTEN_IN ? RESET_PIN_DISABLE_FUSE_IN
                                      : SHIP_RSTDIS;

  function automatic css_src_t src_of(input logic [3:0] sel);
    case (sel)
      SEL_EXT:      src_of = SRC_EXT;
      SEL_RC:       src_of = SRC_RC;
      SEL_K128:     src_of = SRC_K128;
      SEL_LF_SHORT: src_of = SRC_LF;
      SEL_LF_LONG:  src_of = SRC_LF;
      default:      src_of = SRC_RC;
    endcase
  endfunction : src_of

  function automatic logic sel_ok(input logic [3:0] sel);
    case (sel)
      SEL_EXT, SEL_RC, SEL_K128, SEL_LF_SHORT, SEL_LF_LONG: sel_ok = 1'b1;
      default: sel_ok = 1'b0;
    endcase
  endfunction : sel_ok

  function automatic logic [15:0] rst_ck(input css_src_t s);
    if (s == SRC_LF) begin
      rst_ck = RST_CK_LF;
    end else begin
      rst_ck = RST_CK_STD;
    end
  endfunction : rst_ck

  function automatic logic [15:0] wake_ck(input logic [3:0] sel);
    case (sel)
      SEL_LF_SHORT: wake_ck = WAKE_CK_LF1K;
      SEL_LF_LONG:  wake_ck = 16'(LF_WAKE_LONG);
      default:      wake_ck = WAKE_CK_STD;
    endcase
  endfunction : wake_ck

  // reserved start-up code takes the longest delay as a safe fallback
  function automatic css_ms_t ms_of(input logic [1:0] stu,
                                    input logic       rstdis,
                                    input css_src_t   s);
    case (stu)
      STU_FAST: begin
        if (rstdis && s != SRC_LF) begin
          ms_of = MS_SHORT;
        end else begin
          ms_of = MS_NONE;
        end
      end
      STU_MID:  ms_of = MS_SHORT;
      STU_SLOW: ms_of = MS_LONG;
      default:  ms_of = MS_LONG;
    endcase
  endfunction : ms_of

  // 128 kHz source uses the rounder 4/64 ms figures
  // stretched bare delay keeps 4.1 ms even on the 128 kHz source
  function automatic logic [22:0] ms_lim(input css_ms_t    m,
                                         input css_src_t   s,
                                         input logic [1:0] stu);
    if (s == SRC_K128 && stu != STU_FAST) begin
      ms_lim = (m == MS_LONG) ? 23'(K128_LONG_CYC)
                              : 23'(K128_SHORT_CYC);
    end else begin
      ms_lim = (m == MS_LONG) ? 23'(MS_LONG_CYC)
                              : 23'(MS_SHORT_CYC);
    end
  endfunction : ms_lim

  assign src_rise = rise[st_q.src];
  assign ms_mode  = ms_of(st_q.stu, st_q.rstdis, st_q.src);

  always_comb begin
    status = 8'h00;
    status[STAT_SRC_LSB +: 2] = st_q.src;
    status[STAT_RSVD] = st_q.rsvd;
    status[STAT_RSTN] = st_q.core_rst_n;
    status[STAT_RUN]  = st_q.run;
  end

  always_comb begin
    st_d        = st_q;
    st_d.rdata  = 8'h00;
    // core clock only ticks while running
    st_d.sys_en = src_rise & (st_q.state == ST_RUN);
    // watchdog ticks from its own oscillator whatever the source
    st_d.wdt_en = rise[WDT_IDX];
    case (st_q.state)
      ST_LOAD: begin
        // fuses latched once, one cycle after reset release
        st_d.sel    = sel_in;
        st_d.stu    = stu_in;
        st_d.rstdis = rstdis_in;
        st_d.src    = src_of(sel_in);
        st_d.rsvd   = ~sel_ok(sel_in) | (stu_in == STU_RSVD);
        st_d.trim   = FACTORY_CAL_IN;
        st_d.presc  = div8_in ? PRESC_DIV8 : PRESC_DIV1;
        st_d.cnt    = 16'h0000;
        st_d.state  = ST_RST_CK;
      end
      ST_RST_CK: begin
        if (src_rise) begin
          if (st_q.cnt + 16'h0001 == rst_ck(st_q.src)) begin
            st_d.ms    = 23'h00_0000;
            st_d.state = ST_RST_MS;
          end else begin
            st_d.cnt = st_q.cnt + 16'h0001;
          end
        end
      end
      ST_RST_MS: begin
        if (ms_mode == MS_NONE ||
            st_q.ms == ms_lim(ms_mode, st_q.src, st_q.stu)
                       - 23'h00_0001) begin
          st_d.state = ST_RUN;
        end else begin
          st_d.ms = st_q.ms + 23'h00_0001;
        end
      end
      ST_RUN: begin
        if (SLEEP_IN) begin
          st_d.state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (WAKE_IN) begin
          st_d.cnt   = 16'h0000;
          st_d.state = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (src_rise) begin
          if (st_q.cnt + 16'h0001 == wake_ck(st_q.sel)) begin
            st_d.state = ST_RUN;
          end else begin
            st_d.cnt = st_q.cnt + 16'h0001;
          end
        end
      end
      default: begin
        st_d.state = ST_LOAD;
      end
    endcase
    // software cannot write while its core is held in reset
    if (WR_STB_IN && st_q.core_rst_n) begin
      case (ADDR_IN)
        ADDR_TRIM:  st_d.trim  = WR_DATA_IN;
        ADDR_PRESC: st_d.presc = WR_DATA_IN[3:0];
        default:    st_d.trim  = st_d.trim;
      endcase
    end
    if (RD_STB_IN) begin
      case (ADDR_IN)
        ADDR_TRIM:   st_d.rdata = st_q.trim;
        ADDR_PRESC:  st_d.rdata = {4'h0, st_q.presc};
        ADDR_STATUS: st_d.rdata = status;
        default:     st_d.rdata = 8'h00;
      endcase
    end
    st_d.core_rst_n = (st_d.state == ST_RUN) ||
                      (st_d.state == ST_SLEEP) ||
                      (st_d.state == ST_WAKE);
    st_d.run = (st_d.state == ST_RUN);
  end

  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      st_q <= ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign RD_DATA_OUT          = st_q.rdata;
  assign SYS_CLK_EN_OUT       = st_q.sys_en;
  assign WDT_CLK_EN_OUT       = st_q.wdt_en;
  assign CORE_RST_N_OUT       = st_q.core_rst_n;
  assign CORE_RUN_OUT         = st_q.run;
  assign CLK_SRC_OUT          = st_q.src;
  assign CFG_RESERVED_OUT     = st_q.rsvd;
  assign OSCILLATOR_TRIM_OUT  = st_q.trim;
  assign PRESCALER_SELECT_OUT = st_q.presc;

endmodule : css_top

// >>> css_pkg.sv
package css_pkg;

  // time base
  localparam int CLK_MHZ    = 100;
  localparam int T_4P1MS_US = 4100;
  localparam int T_65MS_US  = 65000;
  localparam int T_4MS_US   = 4000;
  localparam int T_64MS_US  = 64000;
  localparam int CYC_4P1MS  = T_4P1MS_US * CLK_MHZ;
  localparam int CYC_65MS   = T_65MS_US * CLK_MHZ;
  localparam int CYC_4MS    = T_4MS_US * CLK_MHZ;
  localparam int CYC_64MS   = T_64MS_US * CLK_MHZ;

  // clock sources, index into the edge vector
  typedef enum logic [1:0] {
    SRC_EXT  = 2'b00,
    SRC_RC   = 2'b01,
    SRC_K128 = 2'b10,
    SRC_LF   = 2'b11
  } css_src_t;
  localparam int WDT_IDX = 4;

  // clock source select fuse codes
  localparam logic [3:0] SEL_EXT      = 4'h0;
  localparam logic [3:0] SEL_RC       = 4'h2;
  localparam logic [3:0] SEL_K128     = 4'h3;
  localparam logic [3:0] SEL_LF_SHORT = 4'h4;
  localparam logic [3:0] SEL_LF_LONG  = 4'h5;

  // start-up time fuse codes
  localparam logic [1:0] STU_FAST = 2'h0;
  localparam logic [1:0] STU_MID  = 2'h1;
  localparam logic [1:0] STU_SLOW = 2'h2;
  localparam logic [1:0] STU_RSVD = 2'h3;

  typedef enum logic [1:0] {
    MS_NONE  = 2'b00,
    MS_SHORT = 2'b01,
    MS_LONG  = 2'b10
  } css_ms_t;

  // cycle counts of the selected source
  localparam logic [15:0] RST_CK_LF    = 16'h0004;
  localparam logic [15:0] RST_CK_STD   = 16'h000E;
  localparam logic [15:0] WAKE_CK_STD  = 16'h0006;
  localparam logic [15:0] WAKE_CK_LF1K = 16'h0400;
  localparam int          WAKE_CK_LF32K = 32768;

  // as-delivered fuse settings
  localparam logic [3:0] SHIP_SEL    = 4'h2;
  localparam logic [1:0] SHIP_STU    = 2'h2;
  localparam logic       SHIP_DIV8   = 1'b1;
  localparam logic       SHIP_RSTDIS = 1'b0;

  // prescaler and trim values
  localparam logic [3:0] PRESC_DIV8 = 4'h3;
  localparam logic [3:0] PRESC_DIV1 = 4'h0;
  localparam logic [7:0] TRIM_RST   = 8'h00;

  // register map
  localparam int         ADDR_W      = 4;
  localparam logic [3:0] ADDR_TRIM   = 4'h0;
  localparam logic [3:0] ADDR_PRESC  = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam int STAT_SRC_LSB = 0;
  localparam int STAT_RSVD    = 2;
  localparam int STAT_RSTN    = 3;
  localparam int STAT_RUN     = 4;

  typedef enum logic [2:0] {
    ST_LOAD   = 3'b000,
    ST_RST_CK = 3'b001,
    ST_RST_MS = 3'b010,
    ST_RUN    = 3'b011,
    ST_SLEEP  = 3'b100,
    ST_WAKE   = 3'b101
  } css_state_t;

endpackage : css_pkg

// >>> css_sync.sv
`timescale 1ns/100ps
module css_sync #(
  parameter int N = 5
) (
  input  wire logic         clk_in,
  input  wire logic         arst_n_in,
  input  wire logic [N-1:0] raw_in,
  output logic      [N-1:0] rise_out
);

  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] s3;
    logic [N-1:0] rise;
    logic [1:0]   age;
  } css_sync_st_t;

  css_sync_st_t st_q;
  css_sync_st_t st_d;

  // first stage feeds only the second
  always_comb begin
    st_d      = st_q;
    st_d.s1   = raw_in;
    st_d.s2   = st_q.s1;
    st_d.s3   = st_q.s2;
    st_d.age  = (st_q.age == 2'h3) ? 2'h3 : st_q.age + 2'h1;
    // no edge until s3 holds a real sample, else a high pin fakes one
    st_d.rise = st_q.s2 & ~st_q.s3 & {N{st_q.age == 2'h3}};
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rise_out = st_q.rise;

endmodule : css_sync

// >>> css_osc_model.sv
`timescale 1ns/100ps
module css_osc_model #(
  parameter int H_EXT  = 33,
  parameter int H_RC   = 27,
  parameter int H_K128 = 41,
  parameter int H_LF   = 52,
  parameter int H_WDT  = 37
) (
  // oscillator square waves
  output logic ext_out,
  output logic rc_out,
  output logic k128_out,
  output logic lf_out,
  output logic wdt_out
);
  // rates are fixed: a step over 2% would need reset
  initial begin
    ext_out = 1'b0;
    rc_out = 1'b0;
    k128_out = 1'b0;
    lf_out = 1'b0;
    wdt_out = 1'b0;
  end
  always #(H_EXT) ext_out = ~ext_out;
  always #(H_RC) rc_out = ~rc_out;
  always #(H_K128) k128_out = ~k128_out;
  always #(H_LF) lf_out = ~lf_out;
  always #(H_WDT) wdt_out = ~wdt_out;
endmodule : css_osc_model

// >>> css_top_chk.sv
`timescale 1ns/100ps
module css_top_chk
  import css_pkg::*;
(
  // clock, reset, fuses, sleep
  input wire logic              CLK_IN,
  input wire logic              ARST_N_IN,
  input wire logic              FUSES_WRITTEN_IN,
  input wire logic [3:0]        CLOCK_SOURCE_SELECT_FUSES_IN,
  input wire logic              DIVIDE_BY_EIGHT_FUSE_IN,
  input wire logic [7:0]        FACTORY_CAL_IN,
  input wire logic              SLEEP_IN,
  // register port and outputs
  input wire logic [ADDR_W-1:0] ADDR_IN,
  input wire logic [7:0]        WR_DATA_IN,
  input wire logic              WR_STB_IN,
  input wire logic              RD_STB_IN,
  input wire logic [7:0]        RD_DATA_OUT,
  input wire logic              SYS_CLK_EN_OUT,
  input wire logic              WDT_CLK_EN_OUT,
  input wire logic              CORE_RST_N_OUT,
  input wire logic              CORE_RUN_OUT,
  input wire logic [1:0]        CLK_SRC_OUT,
  input wire logic [7:0]        OSCILLATOR_TRIM_OUT,
  input wire logic [3:0]        PRESCALER_SELECT_OUT
);
  logic [3:0] sel;
  logic [1:0] src;
  assign sel = FUSES_WRITTEN_IN ? CLOCK_SOURCE_SELECT_FUSES_IN : SHIP_SEL;
  always_comb begin
    case (sel)
      SEL_EXT: src = SRC_EXT;
      SEL_K128: src = SRC_K128;
      SEL_LF_SHORT, SEL_LF_LONG: src = SRC_LF;
      default: src = SRC_RC;
    endcase
  end
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!ARST_N_IN);
  property p_rd_idle;
    !RD_STB_IN |=> RD_DATA_OUT == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
  property p_trim_wr;
    WR_STB_IN && ADDR_IN == ADDR_TRIM && CORE_RST_N_OUT
      |=> OSCILLATOR_TRIM_OUT == $past(WR_DATA_IN);
  endproperty
  a_trim_wr: assert property (p_trim_wr) else $error("trim write lost");
  property p_trim_load;
    $rose(CORE_RST_N_OUT) |-> OSCILLATOR_TRIM_OUT == FACTORY_CAL_IN;
  endproperty
  a_trim_load: assert property (p_trim_load) else $error("trim not loaded");
  property p_presc;
    $rose(CORE_RST_N_OUT) |-> PRESCALER_SELECT_OUT ==
      ((FUSES_WRITTEN_IN ? DIVIDE_BY_EIGHT_FUSE_IN : SHIP_DIV8) ? PRESC_DIV8
                                                                : PRESC_DIV1);
  endproperty
  a_presc: assert property (p_presc) else $error("prescaler reset");
  property p_src;
    CORE_RUN_OUT |-> CLK_SRC_OUT == src;
  endproperty
  a_src: assert property (p_src) else $error("wrong source");
  property p_sleep;
    CORE_RUN_OUT && SLEEP_IN |=> !CORE_RUN_OUT ##1 !SYS_CLK_EN_OUT;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep ignored");
  property p_hold;
    !CORE_RST_N_OUT |-> !CORE_RUN_OUT && !SYS_CLK_EN_OUT;
  endproperty
  a_hold: assert property (p_hold) else $error("ran in reset");
  // watchdog tick must survive sleep and any source
  property p_wdt;
    CORE_RST_N_OUT |-> ##[0:10] WDT_CLK_EN_OUT;
  endproperty
  a_wdt: assert property (p_wdt) else $error("no watchdog tick");
  c_boot: cover property ($rose(CORE_RST_N_OUT));
  c_nap: cover property (CORE_RUN_OUT && SLEEP_IN);
  c_trim: cover property (WR_STB_IN && CORE_RST_N_OUT);
endmodule : css_top_chk

// >>> tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import css_pkg::*;
  logic       clk = 1'b0, arst_n = 1'b0, fw = 1'b0, div8 = 1'b0, rdis = 1'b0;
  logic       slp = 1'b0, wk = 1'b0, wr = 1'b0, rd = 1'b0, rd_p = 1'b0;
  logic [3:0] sel = 4'h0, addr = 4'h0;
  logic [1:0] stu = 2'h0;
  logic [7:0] cal = 8'h00, wdat = 8'h00, x;
  wire  [7:0] rdat, trim;
  wire  [3:0] presc;
  wire  [1:0] src;
  wire        sys_en, wdt_en, rstn, run, rsv, ext, rc, k128, lf, wdo;
  logic [7:0] exp_q[$];
  int         seed = 16, errors = 0, n_checks = 0;
  int         per[4] = '{66, 54, 82, 104};
  int         sel_t[8] = '{0, 2, 3, 4, 5, 9, 3, 2};
  int         stu_t[8] = '{0, 1, 2, 3, 0, 1, 0, 0};
  always #5 clk = ~clk;
  css_osc_model osc_u (.ext_out(ext), .rc_out(rc), .k128_out(k128),
    .lf_out(lf), .wdt_out(wdo));
  css_top #(.MS_SHORT_CYC(20), .MS_LONG_CYC(40), .K128_SHORT_CYC(18),
    .K128_LONG_CYC(36), .LF_WAKE_LONG(64)) dut_u (
    .CLK_IN(clk), .ARST_N_IN(arst_n), .CRYSTAL_INPUT_PIN_IN(ext),
    .RC_OSC_IN(rc), .K128_OSC_IN(k128), .TIMER_OSCILLATOR_PIN_IN(lf),
    .WDT_OSC_IN(wdo), .FUSES_WRITTEN_IN(fw),
    .CLOCK_SOURCE_SELECT_FUSES_IN(sel), .STARTUP_TIME_FUSES_IN(stu),
    .DIVIDE_BY_EIGHT_FUSE_IN(div8), .RESET_PIN_DISABLE_FUSE_IN(rdis),
    .FACTORY_CAL_IN(cal), .SLEEP_IN(slp), .WAKE_IN(wk), .ADDR_IN(addr),
    .WR_DATA_IN(wdat), .WR_STB_IN(wr), .RD_STB_IN(rd), .RD_DATA_OUT(rdat),
    .SYS_CLK_EN_OUT(sys_en), .WDT_CLK_EN_OUT(wdt_en),
    .CORE_RST_N_OUT(rstn), .CORE_RUN_OUT(run), .CLK_SRC_OUT(src),
    .CFG_RESERVED_OUT(rsv), .OSCILLATOR_TRIM_OUT(trim),
    .PRESCALER_SELECT_OUT(presc));
  task automatic chk(input logic [31:0] got, exp, input string m);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask : chk
  // data stands only one cycle after the strobe, so sample it there
  always @(posedge clk) begin
    if (rd_p) chk(rdat, exp_q.pop_front(), "read");
    rd_p <= rd;
  end
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdat <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg
  task automatic boot(input logic f, input logic [3:0] sl,
                      input logic [1:0] st, input logic d, r);
    logic [3:0] es;
    logic [1:0] et, s;
    logic       v;
    int         n, m, p, k, e, w, t;
    es = f ? sl : SHIP_SEL;
    et = f ? st : SHIP_STU;
    v = et == STU_RSVD;
    s = SRC_RC;
    case (es)
      SEL_EXT: s = SRC_EXT;
      SEL_RC: s = SRC_RC;
      SEL_K128: s = SRC_K128;
      SEL_LF_SHORT, SEL_LF_LONG: s = SRC_LF;
      default: v = 1'b1;
    endcase
    n = (s == SRC_LF) ? 4 : 14;
    p = per[s];
    m = (s == SRC_K128) ? 36 : 40;
    if (et == STU_MID) m = (s == SRC_K128) ? 18 : 20;
    if (et == STU_FAST) m = ((f ? r : SHIP_RSTDIS) && s != SRC_LF) ? 20 : 0;
    t = n * p + m * 10;
    @(posedge clk);
    arst_n <= 1'b0;
    fw <= f;
    sel <= sl;
    stu <= st;
    div8 <= d;
    rdis <= r;
    cal <= 8'($random(seed));
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    e = int'($time);
    wr_reg(ADDR_TRIM, ~cal);
    for (k = 0; k < 9000 && rstn !== 1'b1; k++) @(posedge clk);
    e = int'($time) - e;
    chk(e >= t - p && e <= t + p + 100, 1, "reset delay");
    chk(src, s, "source");
    chk(rsv, v, "reserved");
    rd_reg(ADDR_STATUS, {3'h0, 1'h1, 1'h1, v, s});
    rd_reg(ADDR_TRIM, cal);
    rd_reg(ADDR_PRESC, (f ? d : SHIP_DIV8) ? 8'h03 : 8'h00);
    w = (s != SRC_LF) ? 6 : (es == SEL_LF_SHORT) ? 1024 : 64;
    @(posedge clk);
    slp <= 1'b1;
    @(posedge clk);
    slp <= 1'b0;
    wk <= 1'b1;
    @(posedge clk);
    wk <= 1'b0;
    e = int'($time);
    chk(run, 1'b0, "asleep");
    for (k = 0; k < 12000 && run !== 1'b1; k++) @(posedge clk);
    e = int'($time) - e;
    chk(e >= w * p - p && e <= w * p + p + 100, 1, "wake");
  endtask : boot
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude
  initial begin
    boot(1'b0, 4'h0, 2'h0, 1'b0, 1'b1);
    $display("test shipped done");
    for (int i = 0; i < 8; i++) begin
      boot(1'b1, 4'(sel_t[i]), 2'(stu_t[i]), i[0], i == 6);
      $display("test %0d done", i);
    end
    x = 8'($random(seed));
    wr_reg(ADDR_TRIM, x);
    wr_reg(4'hC, ~x);
    rd_reg(ADDR_TRIM, x);
    wr_reg(ADDR_PRESC, 8'hA7);
    rd_reg(ADDR_PRESC, 8'h07);
    rd_reg(4'hC, 8'h00);
    repeat (3) @(posedge clk);
    $display("test registers done");
    conclude();
  end
  initial begin
    #900000;
    errors++;
    conclude();
  end
endmodule : tb_top
bind css_top css_top_chk u_chk (.CLK_IN(CLK_IN), .ARST_N_IN(ARST_N_IN),
  .FUSES_WRITTEN_IN(FUSES_WRITTEN_IN),
  .CLOCK_SOURCE_SELECT_FUSES_IN(CLOCK_SOURCE_SELECT_FUSES_IN),
  .DIVIDE_BY_EIGHT_FUSE_IN(DIVIDE_BY_EIGHT_FUSE_IN),
  .FACTORY_CAL_IN(FACTORY_CAL_IN), .SLEEP_IN(SLEEP_IN), .ADDR_IN(ADDR_IN),
  .WR_DATA_IN(WR_DATA_IN), .WR_STB_IN(WR_STB_IN), .RD_STB_IN(RD_STB_IN),
  .RD_DATA_OUT(RD_DATA_OUT), .SYS_CLK_EN_OUT(SYS_CLK_EN_OUT),
  .WDT_CLK_EN_OUT(WDT_CLK_EN_OUT), .CORE_RST_N_OUT(CORE_RST_N_OUT),
  .CORE_RUN_OUT(CORE_RUN_OUT), .CLK_SRC_OUT(CLK_SRC_OUT),
  .OSCILLATOR_TRIM_OUT(OSCILLATOR_TRIM_OUT),
  .PRESCALER_SELECT_OUT(PRESCALER_SELECT_OUT));
